//--- hdl/emal_pkg.sv
// constants and types for the envelope min-max acquisition latch
// assumes a single 200 MHz clock domain and synchronous active-low reset
//
// Functional notes
// - samples are unsigned eight-bit bytes; all compare and storage paths eight bits
// - in envelope mode each byte meets two comparators: maximum and minimum
// - envelope latch loads an interval's first byte, then only a byte beyond the held extreme, else holds
// - normal and average modes pass every byte unaltered, no comparison
// - at interval end the pair holds that interval's largest and smallest bytes
// - at fastest rate the pair is stored as received, compare bypassed
// - latch enable derives from system clock, aligned to converter output strobe
// - memory writes happen only under time base controller command
// - record holds 1024 samples per channel; addressing covers exactly that
// - trigger resolved within 32-sample window; surplus samples are discarded
// - each sample written to the address of its channel and time position
// - after pretrigger, samples are counted so exactly the record is stored
package emal_pkg;

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int SAMPLE_W     = 8;
  localparam int RECORD_LEN   = 1024;
  localparam int ADDR_W       = 10;
  localparam int TRIG_WINDOW  = 32;
  localparam int TRIG_W       = 5;
  localparam int CHAN_W       = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [SAMPLE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [ADDR_W-1:0]   ADDR_RESET = 10'h000;

  // acquisition modes as presented on the mode input
  typedef enum logic [1:0] {
    EMAL_MODE_NORMAL   = 2'h0,
    EMAL_MODE_AVERAGE  = 2'h1,
    EMAL_MODE_ENVELOPE = 2'h2
  } emal_mode_t;

  // record sequencer states, one-hot
  typedef enum logic [3:0] {
    EMAL_IDLE = 4'h1,
    EMAL_SKIP = 4'h2,
    EMAL_ACQ  = 4'h4,
    EMAL_DONE = 4'h8
  } emal_state_t;

endpackage

//--- hdl/emal_latch.sv
// envelope min-max acquisition latch with record write sequencer
// assumes converter byte stream and its strobe arrive from another clock
// domain and are synchronised here; memory is external, written per cycle
`timescale 1ns/1ps
`default_nettype none

module emal_latch
  import emal_pkg::*;
#(
  parameter int RECORD_SAMPLES = RECORD_LEN
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [SAMPLE_W-1:0] adcByte,
  input  wire logic                adcStrobe,
  input  wire logic [CHAN_W-1:0]   adcChannel,
  input  wire logic                intervalLast,
  input  wire logic [1:0]          modeSelect,
  input  wire logic                fastestRate,
  input  wire logic                recordStart,
  input  wire logic [TRIG_W-1:0]   trigOffset,
  input  wire logic                storeEnable,
  output logic                     memWrite,
  output logic [CHAN_W+ADDR_W-1:0] memAddr,
  output logic [SAMPLE_W-1:0]      memData,
  output logic                     memIsMin,
  output logic                     recordDone,
  output logic                     busy
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [SAMPLE_W-1:0] byteMeta;
  logic [SAMPLE_W-1:0] byteSync;
  logic [CHAN_W-1:0]   chanMeta;
  logic [CHAN_W-1:0]   chanSync;
  logic [2:0]          strobeSh;
  logic                lastMeta;
  logic                lastSync;
  logic                strobeEdge;

  // data and strobe pass two flops; byte settles before strobe edge seen
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      byteMeta <= BYTE_RESET;
      byteSync <= BYTE_RESET;
      chanMeta <= '0;
      chanSync <= '0;
      strobeSh <= 3'h0;
      lastMeta <= 1'b0;
      lastSync <= 1'b0;
    end
    else
    begin
      byteMeta <= adcByte;
      byteSync <= byteMeta;
      chanMeta <= adcChannel;
      chanSync <= chanMeta;
      strobeSh <= {strobeSh[1:0], adcStrobe};
      lastMeta <= intervalLast;
      lastSync <= lastMeta;
    end
  end

  // aligned latch enable
  // one-cycle enable on the rising converter strobe, past the second flop
  assign strobeEdge = strobeSh[1] & ~strobeSh[2];

  // ************************************************************
  // mode capture and record sequencer
  // ************************************************************
  emal_state_t         state;
  emal_mode_t          mode;
  logic                fastMode;
  logic [TRIG_W-1:0]   skipCount;
  logic [ADDR_W:0]     sampleCount;
  logic                sampleTick;
  logic                envMode;

  // mode between records
  // mode and rate are frozen at record start so a record never mixes modes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode     <= EMAL_MODE_NORMAL;
      fastMode <= 1'b0;
    end
    else if ((state == EMAL_IDLE || state == EMAL_DONE) && recordStart)
    begin
      mode     <= emal_mode_t'(modeSelect);
      fastMode <= fastestRate;
    end
  end

  assign envMode = (mode == EMAL_MODE_ENVELOPE);

  // a stored point: every byte in pass-through, an interval end in envelope
  // in the fastest setting each byte is its own interval, so no marker is needed
  assign sampleTick = strobeEdge & (~envMode | fastMode | lastSync);

  // surplus discarded
  // pretrigger offset points are dropped, then exactly one record stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= EMAL_IDLE;
      skipCount   <= '0;
      sampleCount <= '0;
    end
    else
    begin
      case (state)
        EMAL_IDLE, EMAL_DONE:
        begin
          if (recordStart)
          begin
            skipCount   <= trigOffset;
            sampleCount <= '0;
            state       <= (trigOffset == '0) ? EMAL_ACQ : EMAL_SKIP;
          end
        end
        EMAL_SKIP:
        begin
          if (sampleTick && storeEnable)
          begin
            skipCount <= skipCount - 1'b1;
            if (skipCount == 5'h01)
            begin
              state <= EMAL_ACQ;
            end
          end
        end
        EMAL_ACQ:
        begin
          if (sampleTick && storeEnable)
          begin
            sampleCount <= sampleCount + 1'b1;
            if (sampleCount == (ADDR_W+1)'(RECORD_SAMPLES - 1))
            begin
              state <= EMAL_DONE;
            end
          end
        end
        default:
        begin
          state <= EMAL_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // envelope extreme latches
  // ************************************************************
  logic [SAMPLE_W-1:0] maxHeld;
  logic [SAMPLE_W-1:0] minHeld;
  logic                firstOfInterval;
  logic                aboveMax;
  logic                belowMin;

  assign aboveMax = byteSync > maxHeld;
  assign belowMin = byteSync < minHeld;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      maxHeld         <= BYTE_RESET;
      minHeld         <= BYTE_RESET;
      firstOfInterval <= 1'b1;
    end
    else if (state == EMAL_IDLE || state == EMAL_DONE)
    begin
      firstOfInterval <= 1'b1;
    end
    else if (strobeEdge && envMode)
    begin
      if (firstOfInterval || fastMode)
      begin
        maxHeld <= byteSync;
        minHeld <= byteSync;
      end
      else
      begin
        if (aboveMax)
        begin
          maxHeld <= byteSync;
        end
        if (belowMin)
        begin
          minHeld <= byteSync;
        end
      end
      firstOfInterval <= lastSync;
    end
  end

  // ************************************************************
  // memory write port
  // ************************************************************
  logic                pendMin;
  logic [SAMPLE_W-1:0] pendMinData;
  logic [SAMPLE_W-1:0] intervalMax;
  logic [SAMPLE_W-1:0] intervalMin;

  // interval extremes
  // closing byte folded in so the pair includes the interval's last sample
  always_comb
  begin
    intervalMax = maxHeld;
    intervalMin = minHeld;
    if (firstOfInterval || fastMode || byteSync > maxHeld)
    begin
      intervalMax = byteSync;
    end
    if (firstOfInterval || fastMode || byteSync < minHeld)
    begin
      intervalMin = byteSync;
    end
  end

  // channel and position address
  // envelope emits max then min on the next cycle; memIsMin marks the second
  // limitation: a point arriving while the min write is pending would be lost;
  // the edge detector's two-cycle minimum strobe spacing keeps the two apart
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      memWrite    <= 1'b0;
      memAddr     <= '0;
      memData     <= BYTE_RESET;
      memIsMin    <= 1'b0;
      pendMin     <= 1'b0;
      pendMinData <= BYTE_RESET;
    end
    else if (pendMin)
    begin
      memWrite <= 1'b1;
      memData  <= pendMinData;
      memIsMin <= 1'b1;
      pendMin  <= 1'b0;
    end
    else if (state == EMAL_ACQ && sampleTick && storeEnable)
    begin
      memWrite <= 1'b1;
      memAddr  <= {chanSync, sampleCount[ADDR_W-1:0]};
      memIsMin <= 1'b0;
      if (!envMode)
      begin
        memData <= byteSync;
      end
      else
      begin
        memData     <= intervalMax;
        pendMin     <= 1'b1;
        pendMinData <= intervalMin;
      end
    end
    else
    begin
      memWrite <= 1'b0;
      memIsMin <= 1'b0;
    end
  end

  // readout after done
  // done stays high until the next record starts, telling the reader it may fetch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      recordDone <= 1'b0;
    end
    else
    begin
      // an accepted start drops done on the edge the sequencer leaves done
      recordDone <= (state == EMAL_DONE) && !pendMin && !memWrite && !recordStart;
    end
  end

  // combinational so a start request is refused in the very cycle it is busy
  assign busy = (state == EMAL_SKIP) || (state == EMAL_ACQ);

endmodule

`default_nettype wire

//--- tb/emal_latch_monitor.sv
// port checker for the acquisition latch
// assumes store permission stays steady while points are in flight;
// the mode pin may move mid-record, so the mode is taken at an accepted start
`timescale 1ns/1ps
`default_nettype none
module emal_latch_monitor
  import emal_pkg::*;
#(
  parameter int RECORD_SAMPLES = RECORD_LEN
)
(
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic [SAMPLE_W-1:0]      adcByte,
  input wire logic                     adcStrobe,
  input wire logic [CHAN_W-1:0]        adcChannel,
  input wire logic                     intervalLast,
  input wire logic [1:0]               modeSelect,
  input wire logic                     fastestRate,
  input wire logic                     recordStart,
  input wire logic [TRIG_W-1:0]        trigOffset,
  input wire logic                     storeEnable,
  input wire logic                     memWrite,
  input wire logic [CHAN_W+ADDR_W-1:0] memAddr,
  input wire logic [SAMPLE_W-1:0]      memData,
  input wire logic                     memIsMin,
  input wire logic                     recordDone,
  input wire logic                     busy
);
  // **********
  // properties
  // **********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [ADDR_W:0] wcnt;
  logic [1:0]      modeRec;
  // mode as the block froze it when a start was accepted
  always_ff @(posedge clk)
    if (!rst_n) modeRec <= 2'h0;
    else if (recordStart && !busy) modeRec <= modeSelect;
  // stored points since start; min writes share the slot of their max
  always_ff @(posedge clk)
    if (!rst_n || recordStart) wcnt <= '0;
    else if (memWrite && !memIsMin) wcnt <= wcnt + 1'b1;
  property p_pair; memIsMin |-> $past(memWrite) && memAddr == $past(memAddr); endproperty
  a_pair: assert property (p_pair)
    else $error("min write not paired with max");
  property p_order; memIsMin && !fastestRate |-> memData <= $past(memData); endproperty
  a_order: assert property (p_order)
    else $error("min above max");
  property p_pass;
    memWrite && modeRec != EMAL_MODE_ENVELOPE |-> memData == $past(adcByte);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass-through byte altered");
  property p_store; memWrite && !memIsMin |-> $past(storeEnable); endproperty
  a_store: assert property (p_store)
    else $error("write without permission");
  property p_pos; memWrite && !memIsMin |-> memAddr[ADDR_W-1:0] == wcnt[ADDR_W-1:0]; endproperty
  a_pos: assert property (p_pos)
    else $error("write position wrong");
  property p_count; $rose(recordDone) |-> wcnt == (ADDR_W+1)'(RECORD_SAMPLES); endproperty
  a_count: assert property (p_count)
    else $error("record length wrong");
  property p_idle; recordDone |-> !busy; endproperty
  a_idle: assert property (p_idle)
    else $error("done while busy");
  property p_start; recordStart && !busy |=> busy ##0 !recordDone; endproperty
  a_start: assert property (p_start)
    else $error("record did not start");
  c_min: cover property (memIsMin);
  c_done: cover property ($rose(recordDone));
  c_avg: cover property (memWrite && modeRec == EMAL_MODE_AVERAGE);
  c_fast: cover property (memIsMin && fastestRate);
endmodule
bind emal_latch emal_latch_monitor #(.RECORD_SAMPLES(RECORD_SAMPLES)) mon_u (
  .clk(clk), .rst_n(rst_n), .adcByte(adcByte), .adcStrobe(adcStrobe),
  .adcChannel(adcChannel), .intervalLast(intervalLast), .modeSelect(modeSelect),
  .fastestRate(fastestRate), .recordStart(recordStart), .trigOffset(trigOffset),
  .storeEnable(storeEnable), .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
  .memIsMin(memIsMin), .recordDone(recordDone), .busy(busy));
`default_nettype wire

//--- tb/emal_adc_model.sv
// converter model: byte, strobe and interval marker
// assumes the latch synchronises and edge-detects the strobe
`timescale 1ns/1ps
`default_nettype none
module emal_adc_model (
  input  wire logic  clk,
  output logic [7:0] adcByte,
  output logic       adcStrobe,
  output logic [0:0] adcChannel,
  output logic       intervalLast
);
  // ***********
  // stream side
  // ***********
  initial
  begin
    adcByte = 8'h00;
    adcStrobe = 1'b0;
    adcChannel = 1'b0;
    intervalLast = 1'b0;
  end
  // byte set before strobe
  // held through detect, then inverted so a stale byte never looks valid
  task automatic send(input logic [7:0] b, input logic last, input logic [0:0] ch);
    @(negedge clk);
    adcByte = b;
    adcChannel = ch;
    intervalLast = last;
    repeat (3) @(negedge clk);
    adcStrobe = 1'b1;
    repeat (4) @(negedge clk);
    adcStrobe = 1'b0;
    repeat (3) @(negedge clk);
    adcByte = ~b;
    adcChannel = ~ch;
    intervalLast = ~last;
  endtask
endmodule
`default_nettype wire

//--- tb/emal_latch_tb.sv
// self-checking bench for the acquisition latch
// assumes a short record of 8 points; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module emal_latch_tb;
  import emal_pkg::*;
  localparam int RS = 8;
  logic clk, rstN, adcStrobe, intervalLast, fastestRate, recordStart, storeEnable;
  logic memWrite, memIsMin, recordDone, busy;
  logic [7:0] adcByte, memData;
  logic [0:0] adcChannel;
  logic [1:0] modeSelect;
  logic [4:0] trigOffset;
  logic [10:0] memAddr;
  int errors, checksDone;
  logic [7:0] gotD[$];
  logic gotM[$];
  logic [10:0] gotA[$];
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  emal_latch #(.RECORD_SAMPLES(RS)) dut_u (.clk(clk), .rst_n(rstN), .adcByte(adcByte),
    .adcStrobe(adcStrobe), .adcChannel(adcChannel), .intervalLast(intervalLast),
    .modeSelect(modeSelect), .fastestRate(fastestRate), .recordStart(recordStart),
    .trigOffset(trigOffset), .storeEnable(storeEnable), .memWrite(memWrite),
    .memAddr(memAddr), .memData(memData), .memIsMin(memIsMin),
    .recordDone(recordDone), .busy(busy));
  emal_adc_model adc_u (.clk(clk), .adcByte(adcByte), .adcStrobe(adcStrobe),
    .adcChannel(adcChannel), .intervalLast(intervalLast));
  // ***********
  // bench tasks
  // ***********
  // capture at the falling edge, half a cycle clear of the launching edge
  always @(negedge clk)
    if (memWrite === 1'b1)
    begin
      gotD.push_back(memData);
      gotM.push_back(memIsMin);
      gotA.push_back(memAddr);
    end
  task automatic chk(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one record: per bytes to a point, point drop sent with permission low;
  // the mode pin is moved right after the start to show it is ignored mid-record
  task automatic rec(input logic [1:0] m, input int skip, input int per, input int drop,
                     input logic fast, input logic [0:0] ch);
    logic [7:0] b, mx, mn;
    logic [7:0] exp[$];
    logic [10:0] expA[$];
    int n;
    int pos;
    modeSelect = m;
    fastestRate = fast;
    trigOffset = 5'(skip);
    gotD.delete();
    gotM.delete();
    gotA.delete();
    pos = 0;
    recordStart = 1'b1;
    @(negedge clk) recordStart = 1'b0;
    modeSelect = (m == EMAL_MODE_ENVELOPE) ? EMAL_MODE_NORMAL : EMAL_MODE_ENVELOPE;
    for (int i = 0; i < skip + RS + int'(drop >= 0); i++)
    begin
      storeEnable = (i != drop);
      for (int k = 0; k < per; k++)
      begin
        b = 8'(i * 29 + k * 101 + 7);
        mx = (k == 0 || b > mx) ? b : mx;
        mn = (k == 0 || b < mn) ? b : mn;
        adc_u.send(b, k == per - 1 && !fast, ch);
      end
      if (i >= skip && i != drop)
      begin
        exp.push_back(mx);
        expA.push_back({ch, 10'(pos)});
        if (m == EMAL_MODE_ENVELOPE)
        begin
          exp.push_back(mn);
          expA.push_back({ch, 10'(pos)});
        end
        pos++;
      end
    end
    n = 0;
    while (recordDone !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk(recordDone === 1'b1, "record not done");
    chk(gotD.size() == exp.size(), "write count");
    foreach (exp[j])
      if (j < gotD.size())
      begin
        chk(gotD[j] === exp[j] && gotM[j] === (m == 2'h2 && j % 2 == 1), "data");
        chk(gotA[j] === expA[j], "address");
      end
    storeEnable = 1'b1;
  endtask
  // pass-through with two pretrigger points dropped
  task automatic t_normal;
    rec(EMAL_MODE_NORMAL, 2, 1, -1, 1'b0, 1'b0);
  endtask
  // average mode on channel one, one point offered while permission is withheld
  task automatic t_average;
    rec(EMAL_MODE_AVERAGE, 0, 1, 3, 1'b0, 1'b1);
  endtask
  // three bytes per interval on channel one
  task automatic t_envelope;
    rec(EMAL_MODE_ENVELOPE, 1, 3, -1, 1'b0, 1'b1);
  endtask
  // fastest rate: every byte is stored as a pair, no interval marker is sent
  task automatic t_fastest;
    rec(EMAL_MODE_ENVELOPE, 0, 1, -1, 1'b1, 1'b0);
  endtask
  // a byte after the record is complete must not be written
  task automatic t_after_done;
    gotD.delete();
    adc_u.send(8'h5A, 1'b1, 1'b0);
    repeat (4) @(negedge clk);
    chk(gotD.size() == 0, "write while done");
  endtask
  initial
  begin
    rstN = 1'b0;
    modeSelect = 2'h0;
    fastestRate = 1'b0;
    recordStart = 1'b0;
    trigOffset = 5'h00;
    storeEnable = 1'b1;
    errors = 0;
    checksDone = 0;
    repeat (3) @(negedge clk);
    chk(memWrite === 1'b0 && recordDone === 1'b0 && busy === 1'b0, "reset");
    rstN = 1'b1;
    t_normal;
    t_average;
    t_envelope;
    t_fastest;
    t_after_done;
    end_sim;
  end
  // the four records take about 650 cycles; 4000 leaves ample margin
  initial
  begin
    #20000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
